//--- verilog/boundary_scan_tap.sv
// Purpose: Test access port with bypass, instruction and boundary registers
// Assumes: ref_clk is much faster than the test clock pin
// Notes:   Test clock edges are found by oversampling, not used as a clock
//
// Notes on behaviour
// RQ1: Shift-IR puts the instruction register between TDI and TDO.
// RQ2: TRST low forces Test-Logic-Reset at once, without a clock.
// RQ3: Code 1111 is BYPASS and is the instruction after power-up.
// RQ4: BYPASS gives exactly one stage between TDI and TDO in Shift-DR.
// RQ5: Code 0010 is SAMPLE/PRELOAD; boundary register, pins stay functional.
// RQ6: Boundary register is 62 cells long, TAP pins excluded.
// RQ7: Each bit shifted in from TDI pushes a captured bit out TDO.
// RQ8: Code 0000 is EXTEST; boundary register sits in the Shift-DR path.
// RQ9: EXTEST Run-Test/Idle clock drives preloaded outputs and samples inputs.
// RQ10: Scan cells advance on test clock; functional clock pin is data only.
// RQ11: Code 1100 is CLAMP; bypass path, outputs held at boundary values.
// RQ12: Code 1001 is HIGHZ; all outputs float, bypass path selected.
// RQ13: Controller preloads with SAMPLE/PRELOAD before EXTEST or CLAMP.
// RQ14: Capture-DR loads boundary cells from pins, Shift-DR shifts them.
// RQ15: Cell 1 is match output enable and is first out on TDO.
// RQ16: TDO drives only in Shift-IR and Shift-DR, else floats.
// RQ17: Five rises with TMS high reach Test-Logic-Reset, system untouched.
// RQ18: Undriven TMS or TDI counts as logic 1.
// RQ19: TMS, TDI sampled on TCK rise; TDO changes on TCK fall.
// RQ20: Unlisted instruction codes act as BYPASS.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int BSR_W = BSR_LEN,                                      // RQ6
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic             trst_n,
  output logic                  tdo,
  output logic                  tdo_oe_n,
  input  wire logic [BSR_W-1:0] pin_in,
  input  wire logic [BSR_W-1:0] core_out,
  input  wire logic [BSR_W-1:0] core_oe_n,
  output logic      [BSR_W-1:0] pin_out,
  output logic      [BSR_W-1:0] pin_oe_n,
  output logic                  snap_valid,
  input  wire logic             snap_ready,
  output logic      [BSR_W-1:0] snap_data,
  output logic                  snap_overflow,
  output logic      [IR_LEN-1:0] active_instr
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic             tck_s, tms_s, tdi_s;
  logic [BSR_W-1:0] pin_in_s;

  // Floating TMS and TDI settle high in the pads
  pin_sync #(.WIDTH(3), .RESET_VAL({TCK_IDLE, IDLE_PULL, IDLE_PULL}))
  u_ctl_sync (                                                        // RQ18
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({tck, tms, tdi}),
    .sync_out ({tck_s, tms_s, tdi_s})
  );

  // Functional clock pin sits in this vector as plain data
  pin_sync #(.WIDTH(BSR_W), .RESET_VAL('0)) u_pin_sync (              // RQ10
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_in_s)
  );

  // ----------------------------------------------------------------
  // Test clock edge detection
  // ----------------------------------------------------------------
  logic tck_d, next_tck_d;
  logic tck_rise, tck_fall;

  always_comb begin
    next_tck_d = tck_s;
    tck_rise   = tck_s && !tck_d;                                     // RQ19
    tck_fall   = !tck_s && tck_d;                                     // RQ19
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_d <= TCK_IDLE;
    end else begin
      tck_d <= next_tck_d;
    end
  end

  // ----------------------------------------------------------------
  // Controller state and instruction
  // ----------------------------------------------------------------
  tap_state_t        state, next_state;
  logic [IR_LEN-1:0] ir_shift, next_ir_shift;
  logic [IR_LEN-1:0] next_instr;
  logic              tap_rst_n;

  // Pin reset is a direct async clear, so no test clock is needed
  assign tap_rst_n = rst_n && trst_n;                                 // RQ2

  // State walk, taken only on a test clock rise
  always_comb begin
    next_state = state;
    if (tck_rise) begin
      case (state)
        ST_TLR:      next_state = tms_s ? ST_TLR      : ST_IDLE;      // RQ17
        ST_IDLE:     next_state = tms_s ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_DR:   next_state = tms_s ? ST_SEL_IR   : ST_CAP_DR;
        ST_CAP_DR:   next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: next_state = tms_s ? ST_UPD_DR   : ST_PAUSE_DR;
        ST_PAUSE_DR: next_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: next_state = tms_s ? ST_UPD_DR   : ST_SHIFT_DR;
        ST_UPD_DR:   next_state = tms_s ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_IR:   next_state = tms_s ? ST_TLR      : ST_CAP_IR;
        ST_CAP_IR:   next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: next_state = tms_s ? ST_UPD_IR   : ST_PAUSE_IR;
        ST_PAUSE_IR: next_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: next_state = tms_s ? ST_UPD_IR   : ST_SHIFT_IR;
        ST_UPD_IR:   next_state = tms_s ? ST_SEL_DR   : ST_IDLE;
        default:     next_state = ST_TLR;
      endcase
    end
  end

  // Instruction path: capture, shift from TDI, apply on update fall
  always_comb begin
    next_ir_shift = ir_shift;
    next_instr    = active_instr;
    if (tck_rise && state == ST_CAP_IR) begin
      next_ir_shift = IR_CAPTURE;
    end else if (tck_rise && state == ST_SHIFT_IR) begin
      next_ir_shift = {tdi_s, ir_shift[IR_LEN-1:1]};                  // RQ1
    end
    if (state == ST_TLR) begin
      next_instr = INSTR_BYPASS;                                      // RQ3
    end else if (tck_fall && state == ST_UPD_IR) begin
      next_instr = ir_shift;
    end
  end

  // Cleared by either reset so the instruction is bypass from power-up
  always_ff @(posedge ref_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state        <= ST_TLR;                                         // RQ2
      ir_shift     <= IR_CAPTURE;
      active_instr <= INSTR_BYPASS;                                   // RQ3
    end else begin
      state        <= next_state;
      ir_shift     <= next_ir_shift;
      active_instr <= next_instr;
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  logic sel_bsr, is_extest, is_clamp, is_highz;

  // Anything not picking the boundary register falls to bypass
  always_comb begin
    is_extest = (active_instr == INSTR_EXTEST);                       // RQ8
    is_clamp  = (active_instr == INSTR_CLAMP);                        // RQ11
    is_highz  = (active_instr == INSTR_HIGHZ);                        // RQ12
    sel_bsr   = is_extest || (active_instr == INSTR_SAMPLE);          // RQ5 RQ20
  end

  // ----------------------------------------------------------------
  // Data registers and pin drive
  // ----------------------------------------------------------------
  logic             bypass_bit, next_bypass_bit;
  logic [BSR_W-1:0] bsr, next_bsr;
  logic [BSR_W-1:0] upd, next_upd;
  logic             next_tdo, next_tdo_oe_n;
  logic [BSR_W-1:0] next_pin_out, next_pin_oe_n;
  logic             next_overflow;
  logic             fifo_in_ready, fifo_push;

  always_comb begin
    next_bypass_bit = bypass_bit;
    next_bsr        = bsr;
    next_upd        = upd;
    next_tdo        = tdo;
    next_tdo_oe_n   = tdo_oe_n;
    fifo_push       = 1'b0;
    // Bypass stage: zero on capture, one stage while shifting
    if (tck_rise && state == ST_CAP_DR && !sel_bsr) begin
      next_bypass_bit = 1'b0;
    end else if (tck_rise && state == ST_SHIFT_DR && !sel_bsr) begin
      next_bypass_bit = tdi_s;                                        // RQ4
    end
    // Boundary cells, index 0 is cell 1 nearest TDO
    if (tck_rise && state == ST_CAP_DR && sel_bsr) begin
      next_bsr  = pin_in_s;                                           // RQ14
      fifo_push = 1'b1;
    end else if (tck_rise && state == ST_SHIFT_DR && sel_bsr) begin
      next_bsr = {tdi_s, bsr[BSR_W-1:1]};                             // RQ7
    end else if (tck_rise && state == ST_IDLE && is_extest) begin
      next_bsr = pin_in_s;                                            // RQ9
    end
    if (tck_fall && state == ST_UPD_DR && sel_bsr) begin
      next_upd = bsr;
    end
    // Output side moves on the fall and floats outside shift states
    if (tck_fall) begin
      if (state == ST_SHIFT_IR) begin
        next_tdo      = ir_shift[0];                                  // RQ1
        next_tdo_oe_n = 1'b0;
      end else if (state == ST_SHIFT_DR) begin
        next_tdo      = sel_bsr ? bsr[0] : bypass_bit;                // RQ15
        next_tdo_oe_n = 1'b0;
      end else begin
        next_tdo_oe_n = 1'b1;                                         // RQ16
      end
    end
    // Pin mux, registered so the pins never see a decode glitch
    if (is_highz) begin
      next_pin_out  = upd;
      next_pin_oe_n = '1;                                             // RQ12
    end else if (is_extest || is_clamp) begin
      next_pin_out  = upd;                                            // RQ11
      next_pin_oe_n = '0;
    end else begin
      next_pin_out  = core_out;                                       // RQ5
      next_pin_oe_n = core_oe_n;
    end
    next_overflow = snap_overflow || (fifo_push && !fifo_in_ready);
  end

  // Soft state reset leaves these alone so the system keeps running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_bit    <= 1'b0;
      bsr           <= '0;
      upd           <= '0;
      tdo           <= 1'b0;
      tdo_oe_n      <= 1'b1;
      pin_out       <= '0;
      pin_oe_n      <= '1;
      snap_overflow <= 1'b0;
    end else begin
      bypass_bit    <= next_bypass_bit;
      bsr           <= next_bsr;
      upd           <= next_upd;
      tdo           <= next_tdo;
      tdo_oe_n      <= next_tdo_oe_n;
      pin_out       <= next_pin_out;                                  // RQ17
      pin_oe_n      <= next_pin_oe_n;
      snap_overflow <= next_overflow;
    end
  end

  // ----------------------------------------------------------------
  // Capture snapshots for the observer, dropped and flagged if full
  // ----------------------------------------------------------------
  snap_fifo #(.WIDTH(BSR_W), .DEPTH(DEPTH)) u_snap_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (pin_in_s),
    .out_valid (snap_valid),
    .out_ready (snap_ready),
    .out_data  (snap_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [2:0] tms_run;

  // Counts consecutive rises seen with TMS high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tms_run <= '0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        tms_run <= '0;
      end else if (tms_run != TLR_TMS_RISES) begin
        tms_run <= tms_run + 3'h1;
      end
    end
  end

  trst_force_a: assert property ( // RQ2
    @(posedge ref_clk) disable iff (!rst_n)
    !trst_n |-> state == ST_TLR)
    else $error("state not reset while trst_n low");

  tms_five_a: assert property ( // RQ17
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    tms_run == TLR_TMS_RISES |-> state == ST_TLR)
    else $error("five high TMS rises did not reach reset state");

  ir_shift_a: assert property ( // RQ1
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    tck_rise && state == ST_SHIFT_IR
    |=> ir_shift == {$past(tdi_s), $past(ir_shift[IR_LEN-1:1])})
    else $error("instruction register did not shift from TDI");

  reset_bypass_a: assert property ( // RQ3
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    state == ST_TLR |=> active_instr == INSTR_BYPASS)
    else $error("instruction not bypass after reset state");

  bypass_one_a: assert property ( // RQ4
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    tck_fall && state == ST_SHIFT_DR && !sel_bsr
    |=> tdo == $past(bypass_bit) && !tdo_oe_n)
    else $error("bypass stage not on TDO");

  bsr_out_a: assert property ( // RQ15
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    tck_fall && state == ST_SHIFT_DR && sel_bsr |=> tdo == $past(bsr[0]))
    else $error("cell 1 not first on TDO");

  bsr_capture_a: assert property ( // RQ14
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    tck_rise && state == ST_CAP_DR && sel_bsr |=> bsr == $past(pin_in_s))
    else $error("boundary cells did not capture pins");

  tdo_float_a: assert property ( // RQ16
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    tck_fall && state != ST_SHIFT_DR && state != ST_SHIFT_IR
    |=> tdo_oe_n ##1 tdo_oe_n || tck_fall)
    else $error("TDO driven outside shift states");

  highz_pins_a: assert property ( // RQ12
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    is_highz |=> &pin_oe_n)
    else $error("outputs driven under high-Z instruction");

  clamp_hold_a: assert property ( // RQ11
    @(posedge ref_clk) disable iff (!rst_n || !trst_n)
    is_clamp && $stable(upd) |=> pin_out == $past(upd) && ~|pin_oe_n)
    else $error("clamped outputs not held at boundary values");

endmodule
`default_nettype wire

//--- include/tap_pkg.sv
// Purpose: Shared constants and types for the boundary scan test port
// Assumes: Single 100 MHz system clock samples the test clock pin
// Notes:   Instruction codes are four bits wide, all-ones is bypass
package tap_pkg;

  // ----------------------------------------------------------------
  // Register sizes
  // ----------------------------------------------------------------
  localparam int IR_LEN     = 4;
  localparam int BSR_LEN    = 62;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_LEN-1:0] INSTR_BYPASS  = 4'hF;
  localparam logic [IR_LEN-1:0] INSTR_SAMPLE  = 4'h2;
  localparam logic [IR_LEN-1:0] INSTR_EXTEST  = 4'h0;
  localparam logic [IR_LEN-1:0] INSTR_HIGHZ   = 4'h9;
  localparam logic [IR_LEN-1:0] INSTR_CLAMP   = 4'hC;
  // Fixed pattern loaded in Capture-IR, low bits 01
  localparam logic [IR_LEN-1:0] IR_CAPTURE    = 4'h1;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic       IDLE_PULL     = 1'h1;  // Floating pin reads high
  localparam logic       TCK_IDLE      = 1'h0;
  localparam logic [2:0] TLR_TMS_RISES = 3'h5;  // High TMS rises to reset

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR      = 4'b0000,
    ST_IDLE     = 4'b0001,
    ST_SEL_DR   = 4'b0010,
    ST_CAP_DR   = 4'b0011,
    ST_SHIFT_DR = 4'b0100,
    ST_EXIT1_DR = 4'b0101,
    ST_PAUSE_DR = 4'b0110,
    ST_EXIT2_DR = 4'b0111,
    ST_UPD_DR   = 4'b1000,
    ST_SEL_IR   = 4'b1001,
    ST_CAP_IR   = 4'b1010,
    ST_SHIFT_IR = 4'b1011,
    ST_EXIT1_IR = 4'b1100,
    ST_PAUSE_IR = 4'b1101,
    ST_EXIT2_IR = 4'b1110,
    ST_UPD_IR   = 4'b1111
  } tap_state_t;

endpackage

//--- verilog/pin_sync.sv
// Purpose: Two-stage synchroniser for pins entering the ref_clk domain
// Assumes: Each bit is an independent level
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // Two flops, first one read by the second only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

//--- verilog/snap_fifo.sv
// Purpose: Snapshot FIFO with a registered head word
// Assumes: Same clock on both sides
// Notes:   Holds DEPTH words in the array plus one in the head register
`timescale 1ns/1ps
`default_nettype none
module snap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push, pop;

  // ----------------------------------------------------------------
  // Pointer and head control
  // ----------------------------------------------------------------
  always_comb begin
    in_ready       = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    push           = in_valid && in_ready;
    pop            = (count != '0) && (!out_valid || out_ready);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
    next_out_valid = out_valid && !out_ready;
    next_out_data  = out_data;
    if (pop) begin
      next_out_valid = 1'b1;
      next_out_data  = mem[rd_ptr];
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule
`default_nettype wire

//--- tb/jtag_ctl.sv
// Purpose: Board test controller model driving the test port pins
// Assumes: Test clock of 160 ns built from 16 ref_clk periods
// Notes:   Test clock stands low between frames; pins change at ref_clk
`timescale 1ns/1ps
`default_nettype none
module jtag_ctl (
  input  wire logic ref_clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  // Idle pin levels; mode high keeps the controller in reset
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // One test clock period; a floating output reads back as z
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge ref_clk);
    tms <= m;
    tdi <= d;
    // Low half is the entry edge plus seven, so a period is 160 ns
    repeat (7) @(posedge ref_clk);
    o = tdo_oe_n ? 1'hz : tdo;
    tck <= 1'h1;
    repeat (8) @(posedge ref_clk);
    tck <= 1'h0;
  endtask

  // Instruction load from Run-Test/Idle, back to Run-Test/Idle
  task automatic ir(input logic [3:0] c, output logic [3:0] cap);
    logic o;
    step(1'h1, 1'h1, o);
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < 4; i++) begin
      step(i == 3, c[i], o);
      cap[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
  endtask

  // Data scan of n bits, LSB first, ending in Run-Test/Idle
  task automatic dr(input int n, input logic [63:0] d,
                    output logic [63:0] q);
    logic o;
    q = '0;
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_boundary_scan_tap.sv
// Purpose: Self-checking bench for the boundary scan test port
// Assumes: Controller model drives the link; bench drives pins
// Notes:   Preload always precedes EXTEST and CLAMP
`timescale 1ns/1ps
`default_nettype none
module tb_boundary_scan_tap;
  import tap_pkg::*;
  localparam logic [61:0] CORE = 62'h2A5A0F0F3C3C9669;
  localparam logic [61:0] PINS = 62'h123456789ABCDEF1;
  localparam logic [61:0] PRE  = 62'h3C0FF00FA5A55A5B;
  logic        ref_clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  logic        snap_valid, snap_ready, snap_overflow, o;
  logic [61:0] pin_in, core_out, core_oe_n, pin_out, pin_oe_n, snap_data;
  logic [3:0]  active_instr, cap;
  logic [63:0] q;
  int          err_total, checks, cyc;

  boundary_scan_tap i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in),
    .core_out(core_out), .core_oe_n(core_oe_n), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .snap_valid(snap_valid),
    .snap_ready(snap_ready), .snap_data(snap_data),
    .snap_overflow(snap_overflow), .active_instr(active_instr));
  jtag_ctl i_ctl (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n));

  // --------------------------------------------------------------
  // Clock, timeout and reporting
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole run needs about 5.6k cycles; the ceiling leaves margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Lets the detected test clock fall reach the outputs
  task automatic settle;
    repeat (8) @(posedge ref_clk);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    check(active_instr, INSTR_BYPASS);
    check(tdo_oe_n, 1'h1);
    check(pin_out, CORE);
    i_ctl.step(1'h0, 1'h1, o);
    settle();
    check(tdo_oe_n, 1'h1);
  endtask

  // Nine snapshots fill the buffer, the tenth is dropped
  task automatic t_fifo;
    snap_ready <= 1'h0;
    i_ctl.ir(INSTR_SAMPLE, cap);
    check(cap, IR_CAPTURE);
    for (int i = 0; i < 10; i++) begin
      pin_in <= PINS ^ 62'(i);
      i_ctl.dr(1, 64'h0, q);
      settle();
      check(snap_overflow, i == 9);
    end
    for (int i = 0; i < 9; i++) begin
      check(snap_valid, 1'h1);
      check(snap_data, PINS ^ 62'(i));
      @(posedge ref_clk);
      snap_ready <= 1'h1;
      @(posedge ref_clk);
      snap_ready <= 1'h0;
      repeat (4) @(posedge ref_clk);
    end
    check(snap_valid, 1'h0);
    snap_ready <= 1'h1;
    pin_in <= PINS;
  endtask

  // Preload while the core keeps the pins; 64 bits prove 62 cells
  task automatic t_sample;
    i_ctl.ir(INSTR_SAMPLE, cap);
    settle();
    check(active_instr, INSTR_SAMPLE);
    check(pin_out, CORE);
    i_ctl.dr(64, {PRE, 2'h1}, q);
    check(q[61:0], PINS);
    check(q[63:62], 2'h1);
  endtask

  task automatic t_bypass(input logic [3:0] c, input logic [61:0] e_out,
                          input logic [61:0] e_oe);
    i_ctl.ir(c, cap);
    settle();
    check(cap, IR_CAPTURE);
    check(pin_oe_n, e_oe);
    if (c !== INSTR_HIGHZ)
      check(pin_out, e_out);
    i_ctl.dr(8, 64'hA5, q);
    check(q[7:0], 8'h4A);
  endtask

  // Preloaded values drive, one idle clock samples the pins
  task automatic t_extest;
    i_ctl.ir(INSTR_EXTEST, cap);
    settle();
    check(pin_out, PRE);
    check(pin_oe_n, 62'h0);
    pin_in <= ~PINS;
    i_ctl.step(1'h0, 1'h1, o);
    i_ctl.dr(62, {2'h0, PRE}, q);
    check(q[61:0], 62'(~PINS));
  endtask

  // Mode-high reset, then the asynchronous test reset
  task automatic t_tlr;
    for (int i = 0; i < 5; i++)
      i_ctl.step(1'h1, 1'h1, o);
    settle();
    check(active_instr, INSTR_BYPASS);
    check(pin_out, CORE);
    i_ctl.step(1'h0, 1'h1, o);
    i_ctl.ir(INSTR_CLAMP, cap);
    settle();
    @(posedge ref_clk);
    trst_n <= 1'h0;
    @(posedge ref_clk);
    #1 check(active_instr, INSTR_BYPASS);
    @(posedge ref_clk);
    trst_n <= 1'h1;
    i_ctl.step(1'h0, 1'h1, o);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    trst_n = 1'h1;
    snap_ready = 1'h1;
    pin_in = PINS;
    core_out = CORE;
    core_oe_n = ~CORE;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_fifo();
    t_sample();
    t_bypass(INSTR_BYPASS, CORE, ~CORE);
    t_bypass(4'h5, CORE, ~CORE);
    t_extest();
    t_bypass(INSTR_CLAMP, PRE, 62'h0);
    t_bypass(INSTR_HIGHZ, CORE, ~62'h0);
    t_tlr();
    end_of_test();
  end
endmodule
`default_nettype wire
